// *** core/dcrc_pkg.sv ***
// constants, types and register map of the door closing reversal control block
//
// Function
// R01 - automatic mode: any reversing source reopens door itself and asserts reversal output
// R02 - external mode: reversing event drops to reduced speed, asserts output, waits
// R03 - external mode: reopening starts only after the controller's open command
// R04 - duration 00: reversal output held until the open command is asserted
// R05 - duration 01: reversal output held until the door open signal rises
// R06 - duration 02: reversal output is a fixed pulse, default half a second
// R07 - with external mode, controller configures only duration 00 or 02; control writes accept any duration code in either mode
// R08 - closing force above threshold during closing is an obstacle and reversing event
// R09 - autotune off: threshold never changes by obstacles or clean closings
// R10 - autotune is enabled after reset
// R11 - autotune: each force obstacle raises threshold 6 N, capped at ceiling
// R12 - autotune: each clean closing lowers threshold 0.1 N, floored at floor
// R13 - floor force defaults to 110 N, accepts 80 N to 150 N only
// R14 - threshold percentage defaults to 50, accepts 0 to 99
// R15 - ceiling defaults to 150 N, accepts 150 N to 300 N and motor limit
// R16 - percentage 0 gives exactly floor, 99 gives exactly ceiling
// R17 - autotune updates the stored percentage as the threshold moves
// R18 - obstacle detection and force limiter are off inside the closing blind zone
// R19 - blind offset spans -9 mm to +20 mm, default +5 mm
// R20 - centre-opening doors use twice the offset as blind distance
// R21 - contact edge during closing reverses door through complete reopening
// R22 - reversing events act only while closing; reversal output low after reset
// R23 - threshold interpolates linearly between floor and ceiling
package dcrc_pkg;
  // forces are in units of 0.1 N
  localparam int FORCE_W = 12;
  localparam logic [11:0] FLOOR_RST = 12'h044C;
  localparam logic [11:0] FLOOR_MIN = 12'h0320;
  localparam logic [11:0] FLOOR_MAX = 12'h05DC;
  localparam logic [11:0] CEIL_RST = 12'h05DC;
  localparam logic [11:0] CEIL_MIN = 12'h05DC;
  localparam logic [11:0] CEIL_MAX = 12'h0BB8;
  localparam logic [11:0] STEP_UP = 12'h003C;
  localparam logic [11:0] STEP_DOWN = 12'h0001;
  localparam logic [6:0] PCT_RST = 7'h32;
  localparam logic [6:0] PCT_MAX = 7'h63;
  // blind offset in mm, two's complement
  localparam logic signed [7:0] BLIND_RST = 8'sh05;
  localparam logic signed [7:0] BLIND_MIN = -8'sh09;
  localparam logic signed [7:0] BLIND_MAX = 8'sh14;
  // mode codes
  localparam logic REACT_AUTO = 1'b0;
  localparam logic REACT_EXT = 1'b1;
  localparam logic [1:0] DUR_OPEN_CMD = 2'h0;
  localparam logic [1:0] DUR_REOPEN = 2'h1;
  localparam logic [1:0] DUR_PULSE = 2'h2;
  // pulse timing
  localparam logic [15:0] PULSE_MS_RST = 16'h01F4;
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_IN_NS = 1000000;
  localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
  // register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FLOOR = 8'h04;
  localparam logic [7:0] ADDR_CEIL = 8'h08;
  localparam logic [7:0] ADDR_PCT = 8'h0C;
  localparam logic [7:0] ADDR_BLIND = 8'h10;
  localparam logic [7:0] ADDR_PULSE = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_THRESH = 8'h1C;
  // control field layout
  localparam int CTRL_REACT_BIT = 0;
  localparam int CTRL_DUR_LSB = 1;
  localparam int CTRL_TUNE_BIT = 3;
  localparam int CTRL_CENTRE_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h08;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_CMD, ST_REOPEN} dcrc_state_t;
endpackage

// *** core/dcrc_top.sv ***
// door closing reversal control: obstacle reaction, reversal output shaping, force autotune, apb registers
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps
module dcrc_top #(
  parameter int CYCLES_PER_MS = dcrc_pkg::CYCLES_PER_MS,
  parameter logic [11:0] MOTOR_MAX_FORCE = dcrc_pkg::CEIL_MAX
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic openDoorCommand,
  input wire logic reversingContactInput,
  input wire logic closingActive,
  input wire logic closeDone,
  input wire logic doorOpenReached,
  input wire logic signed [15:0] doorPosition,
  input wire logic [11:0] closingForce,
  output logic reversalSignalOut,
  output logic doorOpenSignal,
  output logic reopenRequest,
  output logic reducedSpeed,
  output logic [11:0] forceThreshold
);
  // pin synchronisers
  logic openCmdMeta;
  logic openCmdSync;
  logic contactMeta;
  logic contactSync;
  logic contactPrev;
  // configuration
  logic reactMode;
  logic [1:0] durMode;
  logic forceAutotuneEnable;
  logic centreDoor;
  logic [11:0] forceFloor;
  logic [11:0] forceCeiling;
  logic [6:0] forceThresholdPercent;
  logic signed [7:0] closingBlindOffset;
  logic [15:0] pulseMs;
  logic recalc;
  logic hadObstacle;
  dcrc_pkg::dcrc_state_t state;
  logic [31:0] presc;
  logic [15:0] msLeft;
  // decode and events
  logic apbWr;
  logic apbSetup;
  logic wrErr;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic signed [8:0] blindDist;
  logic blindZone;
  logic detectOn;
  logic forceTrip;
  logic contactTrip;
  logic revEvent;
  logic cleanClose;
  logic msTick;
  logic [11:0] ceilLimit;
  logic [11:0] span;
  logic [18:0] interpProd;
  logic [18:0] interpQuot;
  logic [11:0] interpThr;
  logic [11:0] tunedThr;
  logic [18:0] pctProd;
  logic [18:0] pctQuot;
  logic [6:0] tunedPct;
  logic tuneStep;

  assign pready = 1'b1;
  assign apbWr = psel & penable & pwrite;
  assign apbSetup = psel & ~penable;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      openCmdMeta <= 1'b0;
      openCmdSync <= 1'b0;
      contactMeta <= 1'b0;
      contactSync <= 1'b0;
      contactPrev <= 1'b0;
    end else begin
      openCmdMeta <= openDoorCommand;
      openCmdSync <= openCmdMeta;
      contactMeta <= reversingContactInput;
      contactSync <= contactMeta;
      contactPrev <= contactSync;
    end
  end

  // blind zone: position counts mm still to travel to panels closed, skate open
  always_comb begin
    if (centreDoor) begin
      blindDist = 9'(closingBlindOffset) <<< 1; // R20
    end else begin
      blindDist = 9'(closingBlindOffset);
    end
  end
  assign blindZone = doorPosition <= 16'(blindDist); // R18
  assign detectOn = closingActive & ~blindZone & (state == dcrc_pkg::ST_IDLE); // R22
  assign forceTrip = detectOn & (closingForce > forceThreshold); // R08
  assign contactTrip = detectOn & contactSync & ~contactPrev; // R21
  assign revEvent = forceTrip | contactTrip;
  assign cleanClose = closeDone & ~hadObstacle & ~revEvent;

  // threshold arithmetic
  assign ceilLimit = (MOTOR_MAX_FORCE < dcrc_pkg::CEIL_MAX) ? MOTOR_MAX_FORCE : dcrc_pkg::CEIL_MAX; // R15
  assign span = forceCeiling - forceFloor;
  assign interpProd = 19'(span) * 19'(forceThresholdPercent);
  assign interpQuot = interpProd / 19'(dcrc_pkg::PCT_MAX);
  // 99 percent gives quotient equal to span, so the endpoints are exact
  assign interpThr = forceFloor + interpQuot[11:0]; // R16 R23
  assign tuneStep = forceAutotuneEnable & (forceTrip | cleanClose); // R09
  always_comb begin
    tunedThr = forceThreshold;
    if (forceTrip) begin
      if (13'(forceThreshold) + 13'(dcrc_pkg::STEP_UP) >= 13'(forceCeiling)) begin
        tunedThr = forceCeiling; // R11
      end else begin
        tunedThr = forceThreshold + dcrc_pkg::STEP_UP; // R11
      end
    end else if (cleanClose) begin
      if (forceThreshold <= forceFloor + dcrc_pkg::STEP_DOWN) begin
        tunedThr = forceFloor; // R12
      end else begin
        tunedThr = forceThreshold - dcrc_pkg::STEP_DOWN; // R12
      end
    end
  end
  assign pctProd = 19'(tunedThr - forceFloor) * 19'(dcrc_pkg::PCT_MAX);
  assign pctQuot = (span == 12'h000) ? 19'h0_0000 : pctProd / 19'(span);
  // percent truncates, so a threshold between steps shows the lower percent
  assign tunedPct = (pctQuot > 19'(dcrc_pkg::PCT_MAX)) ? dcrc_pkg::PCT_MAX : pctQuot[6:0]; // R17

  // write checking: out-of-range values are refused and leave the register as it was
  always_comb begin
    wrErr = 1'b0;
    case (paddr)
      dcrc_pkg::ADDR_CTRL: wrErr = 1'b0;
      dcrc_pkg::ADDR_FLOOR: wrErr = pwdata[31:12] != 20'h0_0000 || pwdata[11:0] < dcrc_pkg::FLOOR_MIN ||
                                    pwdata[11:0] > dcrc_pkg::FLOOR_MAX; // R13
      dcrc_pkg::ADDR_CEIL: wrErr = pwdata[31:12] != 20'h0_0000 || pwdata[11:0] < dcrc_pkg::CEIL_MIN ||
                                   pwdata[11:0] > ceilLimit; // R15
      dcrc_pkg::ADDR_PCT: wrErr = pwdata[31:7] != 25'h000_0000 || pwdata[6:0] > dcrc_pkg::PCT_MAX; // R14
      dcrc_pkg::ADDR_BLIND: wrErr = $signed(pwdata) < 32'(dcrc_pkg::BLIND_MIN) ||
                                    $signed(pwdata) > 32'(dcrc_pkg::BLIND_MAX); // R19
      dcrc_pkg::ADDR_PULSE: wrErr = pwdata[31:16] != 16'h0000 || pwdata[15:0] == 16'h0000;
      default: wrErr = 1'b1;
    endcase
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr)
      dcrc_pkg::ADDR_CTRL: next_prdata = {27'h000_0000, centreDoor, forceAutotuneEnable, durMode, reactMode};
      dcrc_pkg::ADDR_FLOOR: next_prdata = {20'h0_0000, forceFloor};
      dcrc_pkg::ADDR_CEIL: next_prdata = {20'h0_0000, forceCeiling};
      dcrc_pkg::ADDR_PCT: next_prdata = {25'h000_0000, forceThresholdPercent};
      dcrc_pkg::ADDR_BLIND: next_prdata = 32'(closingBlindOffset);
      dcrc_pkg::ADDR_PULSE: next_prdata = {16'h0000, pulseMs};
      dcrc_pkg::ADDR_STATUS: next_prdata = {26'h000_0000, hadObstacle, blindZone, doorOpenSignal, reducedSpeed,
                                            reopenRequest, reversalSignalOut};
      dcrc_pkg::ADDR_THRESH: next_prdata = {20'h0_0000, forceThreshold};
      default: next_pslverr = 1'b1;
    endcase
    if (pwrite) begin
      next_prdata = 32'h0000_0000;
      next_pslverr = wrErr;
    end
  end

  // read data and error are captured in the setup cycle, so no wait state is needed
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apbSetup) begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reactMode <= dcrc_pkg::CTRL_RST[dcrc_pkg::CTRL_REACT_BIT];
      durMode <= dcrc_pkg::CTRL_RST[dcrc_pkg::CTRL_DUR_LSB +: 2];
      forceAutotuneEnable <= dcrc_pkg::CTRL_RST[dcrc_pkg::CTRL_TUNE_BIT]; // R10
      centreDoor <= dcrc_pkg::CTRL_RST[dcrc_pkg::CTRL_CENTRE_BIT];
      forceFloor <= dcrc_pkg::FLOOR_RST; // R13
      forceCeiling <= dcrc_pkg::CEIL_RST; // R15
      closingBlindOffset <= dcrc_pkg::BLIND_RST; // R19
      pulseMs <= dcrc_pkg::PULSE_MS_RST; // R06
    end else if (apbWr && !wrErr) begin
      case (paddr)
        dcrc_pkg::ADDR_CTRL: begin
          reactMode <= pwdata[dcrc_pkg::CTRL_REACT_BIT];
          durMode <= pwdata[dcrc_pkg::CTRL_DUR_LSB +: 2];
          forceAutotuneEnable <= pwdata[dcrc_pkg::CTRL_TUNE_BIT];
          centreDoor <= pwdata[dcrc_pkg::CTRL_CENTRE_BIT];
        end
        dcrc_pkg::ADDR_FLOOR: forceFloor <= pwdata[11:0];
        dcrc_pkg::ADDR_CEIL: forceCeiling <= pwdata[11:0];
        dcrc_pkg::ADDR_BLIND: closingBlindOffset <= pwdata[7:0];
        dcrc_pkg::ADDR_PULSE: pulseMs <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // threshold and percent: floor, ceiling and percent writes request a fresh interpolation next cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      forceThresholdPercent <= dcrc_pkg::PCT_RST; // R14
      // interpolation of the reset settings, so the first recalc leaves it unchanged
      forceThreshold <= dcrc_pkg::FLOOR_RST + 12'((19'(dcrc_pkg::CEIL_RST - dcrc_pkg::FLOOR_RST) *
                                                 19'(dcrc_pkg::PCT_RST)) / 19'(dcrc_pkg::PCT_MAX)); // R16 R23
      recalc <= 1'b1;
    end else begin
      if (apbWr && !wrErr && (paddr == dcrc_pkg::ADDR_FLOOR || paddr == dcrc_pkg::ADDR_CEIL ||
                              paddr == dcrc_pkg::ADDR_PCT)) begin
        recalc <= 1'b1;
        if (paddr == dcrc_pkg::ADDR_PCT) begin
          forceThresholdPercent <= pwdata[6:0];
        end
      end else if (tuneStep) begin
        forceThreshold <= tunedThr; // R11 R12
        forceThresholdPercent <= tunedPct; // R17
      end else if (recalc) begin
        forceThreshold <= interpThr; // R16 R23
        recalc <= 1'b0;
      end
    end
  end

  // an obstacle in this closing blocks the clean-close decrement
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hadObstacle <= 1'b0;
    end else if (revEvent) begin
      hadObstacle <= 1'b1;
    end else if (closeDone) begin
      hadObstacle <= 1'b0;
    end
  end

  // reaction sequencing
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= dcrc_pkg::ST_IDLE;
    end else begin
      case (state)
        dcrc_pkg::ST_IDLE: begin
          if (revEvent) begin
            state <= (reactMode == dcrc_pkg::REACT_EXT) ? dcrc_pkg::ST_WAIT_CMD : dcrc_pkg::ST_REOPEN; // R01 R02
          end
        end
        dcrc_pkg::ST_WAIT_CMD: begin
          if (openCmdSync) begin
            state <= dcrc_pkg::ST_REOPEN; // R03
          end
        end
        dcrc_pkg::ST_REOPEN: begin
          if (doorOpenReached) begin
            state <= dcrc_pkg::ST_IDLE; // R21
          end
        end
        default: state <= dcrc_pkg::ST_IDLE;
      endcase
    end
  end
  assign reopenRequest = state == dcrc_pkg::ST_REOPEN;
  assign reducedSpeed = state == dcrc_pkg::ST_WAIT_CMD; // R02

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      doorOpenSignal <= 1'b0;
    end else begin
      doorOpenSignal <= doorOpenReached;
    end
  end

  // pulse timer: a millisecond prescaler keeps the counter narrow
  assign msTick = presc == 32'(CYCLES_PER_MS - 1);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      presc <= 32'h0000_0000;
      msLeft <= 16'h0000;
    end else if (revEvent) begin
      presc <= 32'h0000_0000;
      msLeft <= pulseMs; // R06
    end else if (msLeft != 16'h0000) begin
      presc <= msTick ? 32'h0000_0000 : presc + 32'h0000_0001;
      if (msTick) begin
        msLeft <= msLeft - 16'h0001;
      end
    end
  end

  // reversal output: a new event wins over any clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reversalSignalOut <= 1'b0; // R22
    end else if (revEvent) begin
      reversalSignalOut <= 1'b1; // R01 R02
    end else if (reversalSignalOut) begin
      case (durMode)
        dcrc_pkg::DUR_OPEN_CMD: if (openCmdSync) reversalSignalOut <= 1'b0; // R04
        dcrc_pkg::DUR_REOPEN: if (doorOpenSignal) reversalSignalOut <= 1'b0; // R05
        dcrc_pkg::DUR_PULSE: if (msTick && msLeft == 16'h0001) reversalSignalOut <= 1'b0; // R06
        default: if (openCmdSync) reversalSignalOut <= 1'b0;
      endcase
    end
  end

  // checks
  sequence s_event_ext;
    revEvent && reactMode == dcrc_pkg::REACT_EXT;
  endsequence
  sequence s_enter_wait;
    ##1 state == dcrc_pkg::ST_WAIT_CMD && reducedSpeed && reversalSignalOut;
  endsequence

  property p_auto_reopen;
    @(posedge ref_clk) disable iff (!rst_n)
    revEvent && reactMode == dcrc_pkg::REACT_AUTO |=> reopenRequest && reversalSignalOut;
  endproperty
  a_auto_reopen: assert property (p_auto_reopen) else $error("auto mode did not reopen"); // R01

  property p_ext_wait;
    @(posedge ref_clk) disable iff (!rst_n)
    s_event_ext |-> s_enter_wait;
  endproperty
  a_ext_wait: assert property (p_ext_wait) else $error("external mode did not slow and wait"); // R02

  property p_no_self_open;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(reopenRequest) && $past(state) == dcrc_pkg::ST_WAIT_CMD |-> $past(openCmdSync);
  endproperty
  a_no_self_open: assert property (p_no_self_open) else $error("reopened without open command"); // R03

  property p_hold_until_cmd;
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(reversalSignalOut) && $past(durMode) == dcrc_pkg::DUR_OPEN_CMD |-> $past(openCmdSync);
  endproperty
  a_hold_until_cmd: assert property (p_hold_until_cmd) else $error("reversal dropped before open command"); // R04

  property p_hold_until_open;
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(reversalSignalOut) && $past(durMode) == dcrc_pkg::DUR_REOPEN |-> $past(doorOpenSignal);
  endproperty
  a_hold_until_open: assert property (p_hold_until_open) else $error("reversal dropped before door open"); // R05

  property p_pulse_end;
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(reversalSignalOut) && $past(durMode) == dcrc_pkg::DUR_PULSE |-> $past(msTick) && $past(msLeft) == 16'h0001;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse ended at wrong time"); // R06

  property p_tune_off;
    @(posedge ref_clk) disable iff (!rst_n)
    !forceAutotuneEnable && !recalc |=> $stable(forceThreshold);
  endproperty
  a_tune_off: assert property (p_tune_off) else $error("threshold moved with autotune off"); // R09

  property p_step_up;
    @(posedge ref_clk) disable iff (!rst_n)
    tuneStep && forceTrip && !apbWr |=>
      forceThreshold == ((13'($past(forceThreshold)) + 13'(dcrc_pkg::STEP_UP) >= 13'($past(forceCeiling))) ?
                         $past(forceCeiling) : $past(forceThreshold) + dcrc_pkg::STEP_UP);
  endproperty
  a_step_up: assert property (p_step_up) else $error("obstacle step wrong"); // R11

  property p_bounds;
    @(posedge ref_clk) disable iff (!rst_n)
    forceFloor >= dcrc_pkg::FLOOR_MIN && forceFloor <= dcrc_pkg::FLOOR_MAX &&
    forceCeiling >= dcrc_pkg::CEIL_MIN && forceThresholdPercent <= dcrc_pkg::PCT_MAX;
  endproperty
  a_bounds: assert property (p_bounds) else $error("setting out of range"); // R13

  property p_blind;
    @(posedge ref_clk) disable iff (!rst_n)
    blindZone |-> !revEvent;
  endproperty
  a_blind: assert property (p_blind) else $error("obstacle detected in blind zone"); // R18

  property p_only_closing;
    @(posedge ref_clk) disable iff (!rst_n)
    !closingActive |-> !revEvent ##1 !$rose(reversalSignalOut);
  endproperty
  a_only_closing: assert property (p_only_closing) else $error("reversal outside closing"); // R22
endmodule

// *** tb/dcrc_lift_ctrl_model.sv ***
// lift main controller model: raises the open command some cycles after a reversal
`timescale 1ns/100ps
module dcrc_lift_ctrl_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reversalSignalOut,
  input wire logic reducedSpeed,
  input wire logic doorOpenSignal,
  input wire logic [7:0] cmdDelay,
  output logic openDoorCommand
);
  logic [7:0] waitCnt;
  // level command held until the door reports open, so no early drop mid-reopen
  always_ff @(posedge ref_clk) begin
    if (!rst_n || doorOpenSignal) begin
      openDoorCommand <= 1'b0;
      waitCnt <= 8'h00;
    end else if ((reversalSignalOut || reducedSpeed) && !openDoorCommand) begin
      if (waitCnt >= cmdDelay) openDoorCommand <= 1'b1;
      else waitCnt <= waitCnt + 8'h01;
    end
  end
endmodule

// *** tb/tb.sv ***
// self-checking bench: apb registers, obstacle reactions, reversal output shaping, autotune
`timescale 1ns/100ps
module tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, openDoorCommand, reversalSignalOut, doorOpenSignal, reopenRequest, reducedSpeed;
  logic reversingContactInput = 1'b0;
  logic closingActive = 1'b0;
  logic closeDone = 1'b0;
  logic doorOpenReached = 1'b0;
  logic signed [15:0] doorPosition = 16'sh0000;
  logic [11:0] closingForce = 12'h000;
  logic [11:0] forceThreshold;
  logic [7:0] cmdDelay = 8'h04;
  logic [32:0] expQ[$];
  logic [7:0] addrs[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
  logic [31:0] rstv[7] = '{32'h0000_0008, 32'h0000_044C, 32'h0000_05DC, 32'h0000_0032,
                           32'h0000_0005, 32'h0000_01F4, 32'h0000_0516};
  int miscompares = 0;
  int numChecks = 0;
  int cycles = 0;
  int p, n, cnt;

  always #4 ref_clk = ~ref_clk;

  dcrc_top #(.CYCLES_PER_MS(4)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .openDoorCommand(openDoorCommand), .reversingContactInput(reversingContactInput),
    .closingActive(closingActive), .closeDone(closeDone), .doorOpenReached(doorOpenReached),
    .doorPosition(doorPosition), .closingForce(closingForce), .reversalSignalOut(reversalSignalOut),
    .doorOpenSignal(doorOpenSignal), .reopenRequest(reopenRequest), .reducedSpeed(reducedSpeed),
    .forceThreshold(forceThreshold));

  dcrc_lift_ctrl_model lift (.ref_clk(ref_clk), .rst_n(rst_n), .reversalSignalOut(reversalSignalOut),
    .reducedSpeed(reducedSpeed), .doorOpenSignal(doorOpenSignal), .cmdDelay(cmdDelay),
    .openDoorCommand(openDoorCommand));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic step(input int k); repeat (k) @(posedge ref_clk); endtask
  task automatic endTest(input string name); $display("test %s finished", name); endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    step(1);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    expQ.push_back(e);
    step(1);
    penable <= 1'b1;
    step(1);
    while (pready !== 1'b1) step(1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e); apb(1'b0, a, 32'h0000_0000, {1'b0, e}); endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err); apb(1'b1, a, d, {err, 32'h0}); endtask

  // result watcher: oldest note against each completed access
  always @(posedge ref_clk) begin
    if (psel && penable && pready) begin
      chk(pslverr, expQ[0][32]);
      if (!pwrite) chk(prdata, expQ[0][31:0]);
      void'(expQ.pop_front());
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  function automatic logic [11:0] interp(input int pct);
    return 12'(int'(dcrc_pkg::FLOOR_RST) + int'(dcrc_pkg::CEIL_RST - dcrc_pkg::FLOOR_RST) * pct / 99);
  endfunction

  task automatic setPct(input int v); wr(dcrc_pkg::ADDR_PCT, 32'(v), 1'b0); step(3); endtask

  task automatic clean();
    step(1);
    closingActive <= 1'b1;
    closeDone <= 1'b1;
    step(1);
    closeDone <= 1'b0;
    closingActive <= 1'b0;
    step(3);
  endtask

  task automatic trip(input logic act, input logic viaContact, input logic [15:0] pos, input logic exp);
    int k;
    step(1);
    closingActive <= act;
    doorPosition <= pos;
    if (viaContact) reversingContactInput <= 1'b1;
    else closingForce <= forceThreshold + 12'h001;
    for (k = 0; k < 8 && !reversalSignalOut; k++) step(1);
    chk(reversalSignalOut, exp);
    closingActive <= 1'b0;
    closingForce <= 12'h000;
    reversingContactInput <= 1'b0;
  endtask

  task automatic reopen(input logic expRvs);
    int k;
    for (k = 0; k < 100 && !reopenRequest; k++) step(1);
    chk(reopenRequest, 1'b1);
    chk(reversalSignalOut, expRvs);
    doorOpenReached <= 1'b1;
    for (k = 0; k < 40 && reversalSignalOut; k++) step(1);
    chk(reversalSignalOut, 1'b0);
    step(3);
    chk(doorOpenSignal, 1'b1);
    doorOpenReached <= 1'b0;
    step(4);
  endtask

  initial begin
    void'($urandom(32'h4f25));
    step(20);
    rst_n <= 1'b1;
    step(2);
    chk({reversalSignalOut, reopenRequest, reducedSpeed}, 0);
    chk(forceThreshold, interp(50));
    foreach (addrs[i]) rd(addrs[i], rstv[i]);
    endTest("reset");
    apb(1'b0, 8'h20, 32'h0000_0000, {1'b1, 32'h0});
    wr(dcrc_pkg::ADDR_FLOOR, 32'h0000_031F, 1'b1);
    wr(dcrc_pkg::ADDR_FLOOR, 32'h0000_05DD, 1'b1);
    wr(dcrc_pkg::ADDR_PCT, 32'h0000_0064, 1'b1);
    wr(dcrc_pkg::ADDR_CEIL, 32'h0000_05DB, 1'b1);
    wr(dcrc_pkg::ADDR_CEIL, 32'h0000_0BB9, 1'b1);
    wr(dcrc_pkg::ADDR_BLIND, 32'h0000_0015, 1'b1);
    wr(dcrc_pkg::ADDR_BLIND, 32'hFFFF_FFF6, 1'b1);
    wr(dcrc_pkg::ADDR_BLIND, 32'h0000_0014, 1'b0);
    rd(dcrc_pkg::ADDR_BLIND, 32'h0000_0014);
    for (int i = 0; i < 3; i++) rd(addrs[i + 1], rstv[i + 1]);
    endTest("refusals");
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 0 : (i == 1) ? 99 : int'($urandom % 100);
      setPct(p);
      chk(forceThreshold, interp(p));
    end
    setPct(99);
    clean();
    chk(forceThreshold, 12'h5DB);
    setPct(0);
    clean();
    chk(forceThreshold, 12'h44C);
    endTest("threshold");
    wr(dcrc_pkg::ADDR_CTRL, 32'h0000_000A, 1'b0);
    setPct(99);
    trip(1'b1, 1'b0, 16'h0064, 1'b1);
    step(2);
    chk(forceThreshold, 12'h5DC);
    reopen(1'b1);
    setPct(50);
    trip(1'b1, 1'b0, 16'h0064, 1'b1);
    step(2);
    chk(forceThreshold, 12'h552);
    rd(dcrc_pkg::ADDR_PCT, 32'h0000_0040);
    reopen(1'b1);
    wr(dcrc_pkg::ADDR_CTRL, 32'h0000_0002, 1'b0);
    setPct(0);
    trip(1'b1, 1'b0, 16'h0064, 1'b1);
    step(2);
    chk(forceThreshold, 12'h44C);
    reopen(1'b1);
    endTest("autotune");
    wr(dcrc_pkg::ADDR_CTRL, 32'h0000_000A, 1'b0);
    wr(dcrc_pkg::ADDR_BLIND, 32'h0000_0005, 1'b0);
    trip(1'b1, 1'b0, 16'h0005, 1'b0);
    trip(1'b0, 1'b0, 16'h0064, 1'b0);
    trip(1'b1, 1'b0, 16'h0006, 1'b1);
    reopen(1'b1);
    wr(dcrc_pkg::ADDR_CTRL, 32'h0000_001A, 1'b0);
    trip(1'b1, 1'b0, 16'h000A, 1'b0);
    trip(1'b1, 1'b0, 16'h000B, 1'b1);
    reopen(1'b1);
    endTest("blind zone");
    cmdDelay <= 8'($urandom % 16 + 4);
    wr(dcrc_pkg::ADDR_CTRL, 32'h0000_0009, 1'b0);
    trip(1'b1, 1'b1, 16'h0064, 1'b1);
    chk({reducedSpeed, reopenRequest}, 2'b10);
    for (n = 0; n < 100 && !openDoorCommand; n++) begin
      chk(reopenRequest, 1'b0);
      step(1);
    end
    reopen(1'b0);
    endTest("external");
    wr(dcrc_pkg::ADDR_CTRL, 32'h0000_000E, 1'b0);
    trip(1'b1, 1'b0, 16'h0064, 1'b1);
    rd(dcrc_pkg::ADDR_STATUS, 32'h0000_0023);
    for (n = 0; n < 100 && !openDoorCommand; n++) begin
      chk(reversalSignalOut, 1'b1);
      step(1);
    end
    step(3);
    reopen(1'b0);
    endTest("code three");
    wr(dcrc_pkg::ADDR_PULSE, 32'h0000_0003, 1'b0);
    wr(dcrc_pkg::ADDR_CTRL, 32'h0000_000D, 1'b0);
    trip(1'b1, 1'b0, 16'h0064, 1'b1);
    for (cnt = 0; cnt < 60 && reversalSignalOut; cnt++) step(1);
    chk(cnt >= 11 && cnt <= 14, 1'b1);
    reopen(1'b0);
    endTest("pulse");
    finish_test();
  end
endmodule
